// ==== design/upf_port.sv ====
`timescale 1ns/1ps
`include "upf_map.svh"
module upf_port
  import upf_pkg::*;
#(
  parameter int SYNC_HALF_CYC = `UPF_SYNC_HALF_CYC
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Host-side mode choice and link state.
  input wire logic sync_mode,
  input wire logic link_suspended,
  // Bytes from the host toward the FPGA.
  input wire logic host_in_valid,
  output logic host_in_ready,
  input wire logic [7:0] host_in_data,
  // Bytes from the FPGA toward the host.
  output logic host_out_valid,
  input wire logic host_out_ready,
  output logic [7:0] host_out_data,
  // Packet and wake requests toward the host.
  output logic host_send_now,
  output logic host_wakeup,
  // Parallel FIFO pins.
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic rx_data_available_n,
  output logic tx_space_available_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic send_now_wakeup_n,
  output logic fifo_sync_clock
);
  localparam int DW = `UPF_DATA_W;
  localparam int HW = (SYNC_HALF_CYC > 1) ? $clog2(SYNC_HALF_CYC) : 1;

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev && !cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    rose = !prev && cur;
  endfunction

  // Pin synchronisers; the first stage feeds only the second.
  logic [7:0] din_m_reg, din_s_reg;
  logic rd_m_reg, rd_s_reg, rd_d_reg;
  logic wr_m_reg, wr_s_reg, wr_d_reg;
  logic oe_m_reg, oe_s_reg;
  logic sw_m_reg, sw_s_reg, sw_d_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      din_m_reg <= `UPF_BYTE_RST;
      din_s_reg <= `UPF_BYTE_RST;
      rd_m_reg <= `UPF_STROBE_IDLE;
      rd_s_reg <= `UPF_STROBE_IDLE;
      rd_d_reg <= `UPF_STROBE_IDLE;
      wr_m_reg <= `UPF_STROBE_IDLE;
      wr_s_reg <= `UPF_STROBE_IDLE;
      wr_d_reg <= `UPF_STROBE_IDLE;
      oe_m_reg <= `UPF_STROBE_IDLE;
      oe_s_reg <= `UPF_STROBE_IDLE;
      sw_m_reg <= `UPF_STROBE_IDLE;
      sw_s_reg <= `UPF_STROBE_IDLE;
      sw_d_reg <= `UPF_STROBE_IDLE;
    end else begin
      din_m_reg <= data_in;
      din_s_reg <= din_m_reg;
      rd_m_reg <= rd_n;
      rd_s_reg <= rd_m_reg;
      rd_d_reg <= rd_s_reg;
      wr_m_reg <= wr_n;
      wr_s_reg <= wr_m_reg;
      wr_d_reg <= wr_s_reg;
      oe_m_reg <= oe_n;
      oe_s_reg <= oe_m_reg;
      sw_m_reg <= send_now_wakeup_n;
      sw_s_reg <= sw_m_reg;
      sw_d_reg <= sw_s_reg;
    end
  end

  // Mode follows the host's choice, but only switches while both strobes idle,
  // so a byte in flight is never split across modes.
  upf_mode_e mode_reg, mode_next;
  wire strobes_idle = rd_s_reg && wr_s_reg && rd_d_reg && wr_d_reg;
  wire mode_want_sync = sync_mode && strobes_idle;
  wire mode_want_async = !sync_mode && strobes_idle;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      UPF_MODE_ASYNC: if (mode_want_sync) mode_next = UPF_MODE_SYNC;
      UPF_MODE_SYNC: if (mode_want_async) mode_next = UPF_MODE_ASYNC;
      default: mode_next = UPF_MODE_ASYNC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) mode_reg <= UPF_MODE_ASYNC;
    else mode_reg <= mode_next;
  end

  wire in_sync = (mode_reg == UPF_MODE_SYNC);

  // Transfer clock divided from the core clock; still while in asynchronous mode.
  logic [HW-1:0] div_reg;
  logic sclk_reg;
  wire div_wrap = (div_reg == HW'(SYNC_HALF_CYC - 1));
  wire sclk_rise = in_sync && div_wrap && !sclk_reg;

  always_ff @(posedge clk) begin
    if (!rstn || !in_sync) begin
      div_reg <= '0;
      sclk_reg <= 1'b0;
    end else if (div_wrap) begin
      div_reg <= '0;
      sclk_reg <= !sclk_reg;
    end else begin
      div_reg <= HW'(div_reg + 1'b1);
    end
  end

  assign fifo_sync_clock = sclk_reg;

  // Stream buffers on both data paths.
  upf_stream_if #(.WIDTH(DW)) rx_in ();
  upf_stream_if #(.WIDTH(DW)) rx_out ();
  upf_stream_if #(.WIDTH(DW)) tx_in ();
  upf_stream_if #(.WIDTH(DW)) tx_out ();

  upf_buf #(.WIDTH(DW), .DEPTH(`UPF_BUF_DEPTH)) u_rx_buf (
    .clk(clk),
    .rstn(rstn),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  upf_buf #(.WIDTH(DW), .DEPTH(`UPF_BUF_DEPTH)) u_tx_buf (
    .clk(clk),
    .rstn(rstn),
    .in_s(tx_in),
    .out_s(tx_out)
  );

  assign rx_in.valid = host_in_valid;
  assign rx_in.data = host_in_data;
  assign host_in_ready = rx_in.ready;
  assign host_out_valid = tx_out.valid;
  assign host_out_data = tx_out.data;
  assign tx_out.ready = host_out_ready;

  // Byte moves: clocked mode acts on the transfer clock's rising edge,
  // clockless mode on the strobe's release, when the FPGA's pulse has ended.
  wire bus_to_fpga = !oe_s_reg;
  wire sync_rd = sclk_rise && !rd_s_reg && bus_to_fpga;
  wire sync_wr = sclk_rise && !wr_s_reg && !bus_to_fpga;
  wire async_rd = !in_sync && rose(rd_d_reg, rd_s_reg) && bus_to_fpga;
  wire async_wr = !in_sync && rose(wr_d_reg, wr_s_reg) && !bus_to_fpga;
  // A strobe without data or space is ignored rather than corrupting the buffer.
  assign rx_out.ready = (sync_rd || async_rd) && rx_out.valid;
  assign tx_in.valid = sync_wr || async_wr;
  assign tx_in.data = din_s_reg;

  // Status flags and bus drive, all from flip-flops.
  logic [7:0] dout_reg;
  logic oe_drive_reg;
  logic rxf_n_reg;
  logic txe_n_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout_reg <= `UPF_BYTE_RST;
      oe_drive_reg <= 1'b0;
      rxf_n_reg <= 1'b1;
      txe_n_reg <= 1'b1;
    end else begin
      dout_reg <= rx_out.data;
      oe_drive_reg <= bus_to_fpga;
      rxf_n_reg <= !rx_out.valid;
      txe_n_reg <= !tx_in.ready;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = oe_drive_reg;
  assign rx_data_available_n = rxf_n_reg;
  assign tx_space_available_n = txe_n_reg;

  // Send-immediate and wake requests on the falling edge of the pin.
  logic send_now_reg;
  logic wakeup_reg;
  wire sw_fell = fell(sw_d_reg, sw_s_reg);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      send_now_reg <= 1'b0;
      wakeup_reg <= 1'b0;
    end else begin
      send_now_reg <= sw_fell && !link_suspended;
      wakeup_reg <= sw_fell && link_suspended;
    end
  end

  assign host_send_now = send_now_reg;
  assign host_wakeup = wakeup_reg;
endmodule // upf_port

// ==== design/upf_map.svh ====
`ifndef UPF_MAP_SVH
`define UPF_MAP_SVH

// Width of the parallel data bus.
`define UPF_DATA_W 8
// Entries in each stream buffer.
`define UPF_BUF_DEPTH 2
// Core clock period in nanoseconds.
`define UPF_CLK_PERIOD_NS 100
// Nominal transfer clock rate in megahertz; the core clock cannot reach it.
`define UPF_SYNC_CLK_NOM_MHZ 60
// Transfer clock period used here, in nanoseconds.
`define UPF_SYNC_CLK_PERIOD_NS 800
// Core cycles in half a transfer clock period, derived from the two periods.
`define UPF_SYNC_HALF_CYC ((`UPF_SYNC_CLK_PERIOD_NS / `UPF_CLK_PERIOD_NS) / 2)
// Reset value of the data bus registers.
`define UPF_BYTE_RST 8'h00
// Idle level of the active-low strobes.
`define UPF_STROBE_IDLE 1'b1

`endif

// ==== design/upf_pkg.sv ====
package upf_pkg;
  // One-hot transfer mode.
  typedef enum logic [1:0] {
    UPF_MODE_ASYNC = 2'b01,
    UPF_MODE_SYNC = 2'b10
  } upf_mode_e;

  typedef logic [7:0] upf_byte_t;
endpackage

// ==== design/upf_stream_if.sv ====
`timescale 1ns/1ps
interface upf_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== design/upf_buf.sv ====
`timescale 1ns/1ps
`include "upf_map.svh"
module upf_buf
  import upf_pkg::*;
#(
  parameter int WIDTH = `UPF_DATA_W,
  parameter int DEPTH = `UPF_BUF_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Filling side.
  upf_stream_if.snk in_s,
  // Draining side.
  upf_stream_if.src out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;

  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Full and empty come straight from the count, so the source really stalls.
  assign in_s.ready = (count_reg != CW'(DEPTH));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      if (push && !pop) count_reg <= CW'(count_reg + 1'b1);
      else if (pop && !push) count_reg <= CW'(count_reg - 1'b1);
    end
  end
endmodule // upf_buf

// ==== test/upf_port_checker.sv ====
`timescale 1ns/1ps
module upf_port_checker #(
  parameter int SYNC_HALF_CYC = 4
) (
  // Core side.
  input wire logic clk,
  input wire logic rstn,
  input wire logic sync_mode,
  input wire logic link_suspended,
  input wire logic host_in_ready,
  input wire logic host_out_valid,
  input wire logic host_send_now,
  input wire logic host_wakeup,
  // Pins.
  input wire logic data_oe,
  input wire logic rx_data_available_n,
  input wire logic tx_space_available_n,
  input wire logic oe_n,
  input wire logic send_now_wakeup_n,
  input wire logic fifo_sync_clock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic last_clk_reg;
  logic [7:0] run_cnt_reg;
  // Length of the current transfer clock level, so an uneven high half period shows up.
  always_ff @(posedge clk) begin
    last_clk_reg <= fifo_sync_clock;
    run_cnt_reg <= (!rstn || fifo_sync_clock != last_clk_reg) ? 8'h01 : run_cnt_reg + 8'h01;
  end
  sequence s_sn_fall;
    $fell(send_now_wakeup_n);
  endsequence
  a_oe_dev_drive: assert property ((!oe_n)[*4] |-> data_oe) else $error("bus not handed to device");
  a_oe_fpga_drive: assert property (oe_n[*4] |-> !data_oe) else $error("device drives bus");
  a_rx_full_flag: assert property (!host_in_ready |=> !rx_data_available_n) else $error("rx flag high");
  a_tx_empty_flag: assert property ((!host_out_valid)[*2] |=> !tx_space_available_n) else $error("tx flag high");
  a_send_pulse: assert property (s_sn_fall ##0 !link_suspended |-> ##3 host_send_now ##1 !host_send_now)
    else $error("send pulse wrong");
  a_wake_pulse: assert property (s_sn_fall ##0 link_suspended |-> ##3 host_wakeup && !host_send_now)
    else $error("wake pulse wrong");
  a_sync_clk_idle: assert property ((!sync_mode)[*4] |-> !fifo_sync_clock) else $error("clock runs in async");
  a_sync_half_len: assert property (last_clk_reg && !fifo_sync_clock |-> run_cnt_reg == SYNC_HALF_CYC)
    else $error("clock half period wrong");
endmodule // upf_port_checker

bind upf_port upf_port_checker #(.SYNC_HALF_CYC(SYNC_HALF_CYC)) u_chk (.clk, .rstn, .sync_mode, .link_suspended,
  .host_in_ready, .host_out_valid, .host_send_now, .host_wakeup, .data_oe, .rx_data_available_n,
  .tx_space_available_n, .oe_n, .send_now_wakeup_n, .fifo_sync_clock);

// ==== test/upf_fpga_model.sv ====
`timescale 1ns/1ps
// Keeps to the parallel port only; it has no serial pins at all.
module upf_fpga_model
  import upf_pkg::*;
(
  // Clock and mode.
  input wire logic clk,
  input wire logic sync_mode,
  input wire logic fifo_sync_clock,
  // Pins toward the port.
  input wire logic [7:0] data_out,
  output logic [7:0] data_in,
  output logic rd_n,
  output logic wr_n,
  output logic oe_n
);
  upf_byte_t drv_reg = 8'h00;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    oe_n = 1'b1;
  end
  // A released bus shows the inverse of the last byte, so a stale value cannot pass.
  assign data_in = oe_n ? drv_reg : ~drv_reg;
  task automatic wait_lvl(input logic v);
    for (int i = 0; i < 40 && fifo_sync_clock !== v; i++) @(posedge clk);
  endtask
  task automatic pace(input int n);
    if (sync_mode) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
    end else begin
      repeat (n) @(posedge clk);
    end
  endtask
  task automatic xfer(input logic rd, input upf_byte_t w, output upf_byte_t r);
    oe_n <= !rd;
    drv_reg <= w;
    pace(4);
    if (rd) rd_n <= 1'b0;
    else wr_n <= 1'b0;
    r = data_out;
    pace(5);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // upf_fpga_model

// ==== test/tb_usb_parallel_fifo_port.sv ====
`timescale 1ns/1ps
module tb_usb_parallel_fifo_port;
  import upf_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sync_mode = 1'b0;
  logic link_suspended = 1'b0;
  logic host_in_valid = 1'b0;
  logic host_out_ready = 1'b0;
  logic send_now_wakeup_n = 1'b1;
  upf_byte_t host_in_data = 8'h00;
  upf_byte_t host_out_data, data_in, data_out, b, sb;
  logic host_in_ready, host_out_valid, host_send_now, host_wakeup, data_oe, fifo_sync_clock;
  logic rx_data_available_n, tx_space_available_n, rd_n, wr_n, oe_n;
  int failures = 0;
  int checks_done = 0;
  int seed = 32'h2d6b3430;
  int n, ns, nw;
  upf_byte_t exp_q[$];
  upf_port #(.SYNC_HALF_CYC(4)) uut (.clk, .rstn, .sync_mode, .link_suspended, .host_in_valid, .host_in_ready,
    .host_in_data, .host_out_valid, .host_out_ready, .host_out_data, .host_send_now, .host_wakeup, .data_in,
    .data_out, .data_oe, .rx_data_available_n, .tx_space_available_n, .rd_n, .wr_n, .oe_n, .send_now_wakeup_n,
    .fifo_sync_clock);
  upf_fpga_model fpga (.clk, .sync_mode, .fifo_sync_clock, .data_out, .data_in, .rd_n, .wr_n, .oe_n);
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] exp_pulse(input logic susp);
    return susp ? 8'h01 : 8'h10;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic push(input upf_byte_t v);
    host_in_valid <= 1'b1;
    host_in_data <= v;
    n = 0;
    do @(posedge clk); while (host_in_ready !== 1'b1 && n++ < 20);
    check("push ready", {7'h00, host_in_ready}, 8'h01);
  endtask
  task automatic drain;
    n = 0;
    do @(posedge clk); while (host_out_valid !== 1'b1 && n++ < 40);
    check("drain valid", {7'h00, host_out_valid}, 8'h01);
    check("host out byte", host_out_data, exp_q.pop_front());
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("reset pins", {3'h0, rx_data_available_n, tx_space_available_n, data_oe, host_out_valid, host_in_ready},
      8'h19);
    repeat (2) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      push(b);
    end
    host_in_data <= 8'hff;
    repeat (3) @(posedge clk);
    check("rx full ready", {7'h00, host_in_ready}, 8'h00);
    host_in_valid <= 1'b0;
    repeat (2) begin
      check("rx flag", {7'h00, rx_data_available_n}, 8'h00);
      fpga.xfer(1'b1, 8'h00, b);
      check("rx byte", b, exp_q.pop_front());
    end
    check("rx empty", {7'h00, rx_data_available_n}, 8'h01);
    $display("rx test done");
    // The third write meets a full buffer while the host stalls and must vanish.
    repeat (3) begin
      b = 8'($random(seed));
      if (exp_q.size() < 2) exp_q.push_back(b);
      fpga.xfer(1'b0, b, b);
    end
    check("tx full flag", {7'h00, tx_space_available_n}, 8'h01);
    host_out_ready <= 1'b1;
    repeat (2) drain();
    @(posedge clk);
    check("tx empty", {7'h00, host_out_valid}, 8'h00);
    host_out_ready <= 1'b0;
    $display("tx test done");
    for (int s = 0; s < 2; s++) begin
      link_suspended <= s[0];
      send_now_wakeup_n <= 1'b0;
      ns = 0;
      nw = 0;
      // Counting starts at the fall, since the pulse comes while the pin is still low.
      for (int i = 0; i < 14; i++) begin
        @(posedge clk);
        if (i == 3) send_now_wakeup_n <= 1'b1;
        ns += int'(host_send_now === 1'b1);
        nw += int'(host_wakeup === 1'b1);
      end
      check("send pulses", {ns[3:0], nw[3:0]}, exp_pulse(s[0]));
    end
    link_suspended <= 1'b0;
    $display("send test done");
    sync_mode <= 1'b1;
    sb = 8'($random(seed));
    push(sb);
    host_in_valid <= 1'b0;
    repeat (12) @(posedge clk);
    fpga.xfer(1'b0, 8'hff, b);
    exp_q.push_back(8'hff);
    host_out_ready <= 1'b1;
    drain();
    fpga.xfer(1'b1, 8'h00, b);
    check("sync rd byte", b, sb);
    check("sync rx empty", {7'h00, rx_data_available_n}, 8'h01);
    $display("sync test done");
    summarize();
  end
  // The whole sequence needs well under a thousand cycles; five thousand means a hang.
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule // tb_usb_parallel_fifo_port
